// file: rtl/per_reply.sv
// Reply packet builder: error and normal replies, reports, CRC, reply deadline
// Behaviour
// - Failed standard command: type is command OR 0xC0, length two.
// - Standard error data: byte0 interface (0 serial, 1 USB), byte1 error id.
// - Sub-command error: subnum, interface, error id; length sent as three.
// - Generic ids: 1 unknown, 2 command, 3 length, 4 flash write, 5 read.
// - Id 6 fan board absent, 7 fan board gives no reply.
// - Ids 8 to 17 cover removable-card and file faults.
// - Ids 18 to 21 cover graphics stream and video faults.
// - Id 22 pin not for power, 23 interface disabled, 24 unavailable.
// - Every command gets its answer within 500 ms; the timer forces an unknown error only at 500 ms, its packet goes out after.
// - Reports go out any time, even between command and answer; the code sends them only between packets, after any ready reply.
// - Type top bits: 00 command, 01 response, 10 report, 11 error.
// - Answer type low six bits equal the command's low six bits.
// - Each packet ends with 16-bit CRC, low byte first.
// - Exactly one answer packet per command.
`timescale 1ns/100ps
`default_nettype none
module per_reply #(
   parameter int TIMEOUT_CYC = per_pkg::REPLY_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic cmdValid,
   input wire per_pkg::per_cmd_s cmd,
   output logic cmdReady,
   input wire logic resValid,
   input wire per_pkg::per_res_s res,
   input wire logic rptValid,
   input wire per_pkg::per_rpt_s rpt,
   output logic rptReady,
   input wire logic plValid,
   input wire logic [7:0] plData,
   output logic plReady,
   output logic plForReport,
   output logic txValid,
   input wire logic txReady,
   output per_pkg::per_tx_s txData
);
   localparam int TW = $clog2(TIMEOUT_CYC + 1);
   localparam logic [TW-1:0] T_LAST = TW'(TIMEOUT_CYC - 1);
   localparam logic [TW-1:0] T_ONE = TW'(1);

   // ************************************************************
   // Functions
   // ************************************************************
   function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] x;
      x = c;
      for (int i = 0; i < per_pkg::BYTE_W; i++) begin
         x = (x[0] ^ d[i]) ? ((x >> 1) ^ per_pkg::CRC_POLY) : (x >> 1);
      end
      return x;
   endfunction

   function automatic logic [7:0] ifCode(input logic usb);
      return usb ? per_pkg::IF_USB : per_pkg::IF_SERIAL;
   endfunction

   function automatic logic [7:0] errByte(input logic [7:0] idx, input per_pkg::per_res_s r, input logic usb);
      logic [7:0] b;
      b = r.errId;
      if (r.isSub) begin
         if (idx == per_pkg::IDX_FIRST) begin
            b = r.subNum;
         end else if (idx == per_pkg::IDX_SECOND) begin
            b = ifCode(usb);
         end
      end else if (idx == per_pkg::IDX_FIRST) begin
         b = ifCode(usb);
      end
      return b;
   endfunction

   // Unlisted ids would mislead the host, so they fold to unknown
   function automatic logic [7:0] cleanId(input logic [7:0] id);
      return (id >= per_pkg::ERR_UNKNOWN && id <= per_pkg::ERR_MAX) ? id : per_pkg::ERR_UNKNOWN;
   endfunction

   // ************************************************************
   // State
   // ************************************************************
   per_pkg::per_state_e state_r, state_nxt;
   per_pkg::per_cmd_s cmd_r, cmd_nxt;
   per_pkg::per_res_s res_r, res_nxt;
   logic pending_r, pending_nxt, haveRes_r, haveRes_nxt, isRpt_r, isRpt_nxt;
   logic [TW-1:0] timer_r, timer_nxt;
   logic [7:0] hdrType_r, hdrType_nxt, hdrLen_r, hdrLen_nxt, idx_r, idx_nxt;
   logic [1:0] dest_r, dest_nxt;
   logic [15:0] crc_r, crc_nxt, crcOut;
   logic [7:0] curByte;
   logic push, fifoInRdy, useErr;
   per_pkg::per_tx_s fifoIn;

   // Host waits for each answer, so one outstanding command is enough
   assign cmdReady = !pending_r;
   assign crcOut = crc_r ^ per_pkg::CRC_XOROUT;
   assign useErr = !isRpt_r && res_r.fail;
   assign plForReport = isRpt_r;
   assign fifoIn = '{dest: dest_r, data: curByte};

   // ************************************************************
   // Command tracking and reply deadline
   // ************************************************************
   always_comb begin
      cmd_nxt = cmd_r;
      res_nxt = res_r;
      pending_nxt = pending_r;
      haveRes_nxt = haveRes_r;
      timer_nxt = timer_r;
      if (cmdValid && cmdReady) begin
         pending_nxt = 1'b1;
         cmd_nxt = cmd;
         haveRes_nxt = 1'b0;
         timer_nxt = '0;
      end else if (pending_r && !haveRes_r) begin
         if (resValid) begin
            // Later results for this command are dropped
            haveRes_nxt = 1'b1;
            res_nxt = res;
            res_nxt.errId = cleanId(res.errId);
         end else if (timer_r == T_LAST) begin
            // Engine overran the deadline: answer with unknown error
            haveRes_nxt = 1'b1;
            res_nxt = '{fail: 1'b1, isSub: 1'b0, subNum: 8'h00, errId: per_pkg::ERR_UNKNOWN, len: 8'h00};
         end else begin
            timer_nxt = timer_r + T_ONE;
         end
      end
      if (state_r == per_pkg::ST_CRCH && push && !isRpt_r) begin
         pending_nxt = 1'b0;
         haveRes_nxt = 1'b0;
      end
   end

   // ************************************************************
   // Packet sequencer
   // ************************************************************
   always_comb begin
      state_nxt = state_r;
      isRpt_nxt = isRpt_r;
      hdrType_nxt = hdrType_r;
      hdrLen_nxt = hdrLen_r;
      dest_nxt = dest_r;
      idx_nxt = idx_r;
      crc_nxt = crc_r;
      curByte = 8'h00;
      push = 1'b0;
      rptReady = 1'b0;
      plReady = 1'b0;
      case (state_r)
         per_pkg::ST_IDLE: begin
            crc_nxt = per_pkg::CRC_INIT;
            // Replies take precedence; reports fill the gaps between packets
            if (pending_r && haveRes_r) begin
               isRpt_nxt = 1'b0;
               hdrType_nxt = {res_r.fail ? per_pkg::CLS_ERR : per_pkg::CLS_RESP,
                              cmd_r.cmdType[per_pkg::CODE_W-1:0]};
               hdrLen_nxt = !res_r.fail ? res_r.len :
                            res_r.isSub ? per_pkg::LEN_ERR_SUB : per_pkg::LEN_ERR_STD;
               dest_nxt = cmd_r.usb ? per_pkg::DEST_USB : per_pkg::DEST_SERIAL;
               state_nxt = per_pkg::ST_TYPE;
            end else if (rptValid) begin
               rptReady = 1'b1;
               isRpt_nxt = 1'b1;
               hdrType_nxt = {per_pkg::CLS_RPT, rpt.code};
               hdrLen_nxt = rpt.len;
               dest_nxt = per_pkg::DEST_ALL;
               state_nxt = per_pkg::ST_TYPE;
            end
         end
         per_pkg::ST_TYPE: begin
            curByte = hdrType_r;
            push = fifoInRdy;
            if (push) begin
               crc_nxt = crcByte(crc_r, curByte);
               state_nxt = per_pkg::ST_LEN;
            end
         end
         per_pkg::ST_LEN: begin
            curByte = hdrLen_r;
            push = fifoInRdy;
            if (push) begin
               crc_nxt = crcByte(crc_r, curByte);
               idx_nxt = 8'h00;
               state_nxt = (hdrLen_r == 8'h00) ? per_pkg::ST_CRCL : per_pkg::ST_DATA;
            end
         end
         per_pkg::ST_DATA: begin
            if (useErr) begin
               // Error packet draws nothing from the payload port
               curByte = errByte(idx_r, res_r, cmd_r.usb);
               push = fifoInRdy;
            end else begin
               curByte = plData;
               plReady = fifoInRdy;
               push = plValid && fifoInRdy;
            end
            if (push) begin
               crc_nxt = crcByte(crc_r, curByte);
               idx_nxt = idx_r + 8'h01;
               if (idx_r == hdrLen_r - 8'h01) begin
                  state_nxt = per_pkg::ST_CRCL;
               end
            end
         end
         per_pkg::ST_CRCL: begin
            curByte = crcOut[7:0];
            push = fifoInRdy;
            if (push) begin
               state_nxt = per_pkg::ST_CRCH;
            end
         end
         per_pkg::ST_CRCH: begin
            curByte = crcOut[15:8];
            push = fifoInRdy;
            if (push) begin
               state_nxt = per_pkg::ST_IDLE;
            end
         end
         default: begin
            state_nxt = per_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= per_pkg::ST_IDLE;
         cmd_r <= '0;
         res_r <= '0;
         pending_r <= 1'b0;
         haveRes_r <= 1'b0;
         isRpt_r <= 1'b0;
         timer_r <= '0;
         hdrType_r <= 8'h00;
         hdrLen_r <= 8'h00;
         idx_r <= 8'h00;
         dest_r <= 2'b00;
         crc_r <= per_pkg::CRC_INIT;
      end else begin
         state_r <= state_nxt;
         cmd_r <= cmd_nxt;
         res_r <= res_nxt;
         pending_r <= pending_nxt;
         haveRes_r <= haveRes_nxt;
         isRpt_r <= isRpt_nxt;
         timer_r <= timer_nxt;
         hdrType_r <= hdrType_nxt;
         hdrLen_r <= hdrLen_nxt;
         idx_r <= idx_nxt;
         dest_r <= dest_nxt;
         crc_r <= crc_nxt;
      end
   end

   // ************************************************************
   // Output buffer
   // ************************************************************
   // Host drains this; a slow host stalls the sequencer, never drops bytes
   per_fifo #(
      .W(per_pkg::FIFO_W),
      .D(per_pkg::FIFO_D)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .inValid(push),
      .inReady(fifoInRdy),
      .inData(fifoIn),
      .outValid(txValid),
      .outReady(txReady),
      .outData(txData)
   );

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   errtype_check_a: assert property (state_r == per_pkg::ST_TYPE && push && useErr |->
      curByte == {per_pkg::CLS_ERR, cmd_r.cmdType[per_pkg::CODE_W-1:0]})
      else $error("error reply type byte wrong");
   okresp_type_a: assert property (state_r == per_pkg::ST_TYPE && push && !isRpt_r && !res_r.fail |->
      curByte == {per_pkg::CLS_RESP, cmd_r.cmdType[per_pkg::CODE_W-1:0]})
      else $error("response type byte wrong");
   errlen_check_a: assert property (state_r == per_pkg::ST_LEN && push && useErr |->
      curByte == (res_r.isSub ? per_pkg::LEN_ERR_SUB : per_pkg::LEN_ERR_STD) ##1 state_r == per_pkg::ST_DATA)
      else $error("error reply length wrong");
   iface_byte_a: assert property (state_r == per_pkg::ST_DATA && push && useErr && !res_r.isSub &&
      idx_r == per_pkg::IDX_FIRST |-> curByte == ifCode(cmd_r.usb) ##1
      (state_r == per_pkg::ST_DATA && curByte == res_r.errId))
      else $error("standard error data wrong");
   reply_deadline_a: assert property (pending_r && !haveRes_r |-> timer_r <= T_LAST)
      else $error("reply deadline overrun");
   timeout_unknown_a: assert property (pending_r && !haveRes_r && !resValid && !cmdValid &&
      timer_r == T_LAST |=> haveRes_r && res_r.fail && res_r.errId == per_pkg::ERR_UNKNOWN)
      else $error("timeout did not raise unknown error");
   report_header_a: assert property (rptReady |=>
      hdrType_r == {per_pkg::CLS_RPT, $past(rpt.code)} && dest_r == per_pkg::DEST_ALL && isRpt_r)
      else $error("report header wrong");
   one_reply_a: assert property (state_r == per_pkg::ST_CRCH && push && !isRpt_r |=>
      !pending_r && cmdReady && state_r == per_pkg::ST_IDLE)
      else $error("command not closed after its reply");
   crc_frozen_a: assert property (state_r == per_pkg::ST_CRCL && push |=>
      state_r == per_pkg::ST_CRCH && crc_r == $past(crc_r))
      else $error("crc changed during crc bytes");
   err_no_payload_a: assert property (state_r == per_pkg::ST_DATA && useErr |-> !plReady)
      else $error("error packet consumed payload");

   sub_err_c: cover property (state_r == per_pkg::ST_CRCH && push && useErr && res_r.isSub);
   timeout_c: cover property (pending_r && !haveRes_r && timer_r == T_LAST && !resValid);
   rpt_between_c: cover property (rptReady && pending_r);
   fifo_full_c: cover property (state_r == per_pkg::ST_DATA && !fifoInRdy);
endmodule
`default_nettype wire

// file: pkg/per_pkg.sv
// Shared constants, types and states of the packet error reply block
package per_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_HZ = 125_000_000;
   localparam int REPLY_MS = 500;
   localparam int REPLY_CYC = (CLK_HZ / 1000) * REPLY_MS;

   // ************************************************************
   // Packet layout
   // ************************************************************
   localparam int BYTE_W = 8;
   localparam int CODE_W = 6;
   localparam logic [1:0] CLS_CMD = 2'b00;
   localparam logic [1:0] CLS_RESP = 2'b01;
   localparam logic [1:0] CLS_RPT = 2'b10;
   localparam logic [1:0] CLS_ERR = 2'b11;
   localparam logic [7:0] IF_SERIAL = 8'h00;
   localparam logic [7:0] IF_USB = 8'h01;
   localparam logic [7:0] LEN_ERR_STD = 8'h02;
   localparam logic [7:0] LEN_ERR_SUB = 8'h03;
   localparam logic [7:0] IDX_FIRST = 8'h00;
   localparam logic [7:0] IDX_SECOND = 8'h01;
   localparam logic [1:0] DEST_SERIAL = 2'b01;
   localparam logic [1:0] DEST_USB = 2'b10;
   localparam logic [1:0] DEST_ALL = 2'b11;

   // ************************************************************
   // Error identifiers
   // ************************************************************
   localparam logic [7:0] ERR_UNKNOWN = 8'h01;
   localparam logic [7:0] ERR_BAD_CMD = 8'h02;
   localparam logic [7:0] ERR_BAD_LEN = 8'h03;
   localparam logic [7:0] ERR_NV_WRITE = 8'h04;
   localparam logic [7:0] ERR_NV_READ = 8'h05;
   localparam logic [7:0] ERR_FAN_ABSENT = 8'h06;
   localparam logic [7:0] ERR_FAN_NOREPLY = 8'h07;
   localparam logic [7:0] ERR_CARD_FIRST = 8'h08;
   localparam logic [7:0] ERR_CARD_LAST = 8'h11;
   localparam logic [7:0] ERR_GFX_FIRST = 8'h12;
   localparam logic [7:0] ERR_GFX_TIMEOUT = 8'h15;
   localparam logic [7:0] ERR_PIN_NOT_ATX = 8'h16;
   localparam logic [7:0] ERR_IF_DISABLED = 8'h17;
   localparam logic [7:0] ERR_IF_ABSENT = 8'h18;
   localparam logic [7:0] ERR_MAX = ERR_IF_ABSENT;

   // ************************************************************
   // Check code
   // ************************************************************
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'h8408;
   localparam logic [15:0] CRC_XOROUT = 16'hFFFF;

   // ************************************************************
   // Buffer
   // ************************************************************
   localparam int FIFO_W = 10;
   localparam int FIFO_D = 8;

   // ************************************************************
   // Types
   // ************************************************************
   typedef struct packed {
      logic [7:0] cmdType;
      logic usb;
   } per_cmd_s;

   typedef struct packed {
      logic fail;
      logic isSub;
      logic [7:0] subNum;
      logic [7:0] errId;
      logic [7:0] len;
   } per_res_s;

   typedef struct packed {
      logic [5:0] code;
      logic [7:0] len;
   } per_rpt_s;

   typedef struct packed {
      logic [1:0] dest;
      logic [7:0] data;
   } per_tx_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_TYPE = 3'b001,
      ST_LEN = 3'b011,
      ST_DATA = 3'b010,
      ST_CRCL = 3'b110,
      ST_CRCH = 3'b111
   } per_state_e;

endpackage

// file: rtl/per_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module per_fifo #(
   parameter int W = 10,
   parameter int D = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [W-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [W-1:0] outData
);
   localparam int AW = $clog2(D);
   localparam logic [AW:0] DEPTH = (AW + 1)'(D);
   localparam logic [AW:0] ONE = (AW + 1)'(1);

   logic [W-1:0] mem_r [D];
   logic [W-1:0] mem_nxt [D];
   logic [AW:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt, count_r, count_nxt;
   logic doWr, doRd;

   assign inReady = count_r != DEPTH;
   assign outValid = count_r != '0;
   assign outData = mem_r[rdPtr_r[AW-1:0]];

   always_comb begin
      doWr = inValid && inReady;
      doRd = outValid && outReady;
      mem_nxt = mem_r;
      wrPtr_nxt = wrPtr_r;
      rdPtr_nxt = rdPtr_r;
      count_nxt = count_r;
      if (doWr) begin
         mem_nxt[wrPtr_r[AW-1:0]] = inData;
         wrPtr_nxt = (wrPtr_r[AW-1:0] == AW'(D - 1)) ? '0 : wrPtr_r + ONE;
      end
      if (doRd) begin
         rdPtr_nxt = (rdPtr_r[AW-1:0] == AW'(D - 1)) ? '0 : rdPtr_r + ONE;
      end
      if (doWr && !doRd) begin
         count_nxt = count_r + ONE;
      end else if (doRd && !doWr) begin
         count_nxt = count_r - ONE;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
         for (int i = 0; i < D; i++) begin
            mem_r[i] <= '0;
         end
      end else begin
         wrPtr_r <= wrPtr_nxt;
         rdPtr_r <= rdPtr_nxt;
         count_r <= count_nxt;
         mem_r <= mem_nxt;
      end
   end
endmodule
`default_nettype wire

// file: sim/per_host_model.sv
// Host side model: drains reply bytes into a queue, can stall the link
`timescale 1ns/100ps
`default_nettype none
module per_host_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic txValid,
   input wire per_pkg::per_tx_s txData,
   input wire logic hold,
   input wire logic slow,
   output logic txReady
);
   // ************************************************************
   // Receive buffer
   // ************************************************************
   per_pkg::per_tx_s rxQ[$];
   logic [1:0] cnt;

   // Unbounded queue, so the host never falls behind the link
   // Held back to model a blocked receive path; slow drops one cycle in four
   always @(posedge clk) begin
      if (rst) begin
         cnt <= 2'h0;
         txReady <= 1'b0;
      end else begin
         cnt <= cnt + 2'h1;
         if (txValid && txReady) begin
            rxQ.push_back(txData);
         end
         txReady <= !hold && !(slow && cnt == 2'h3);
      end
   end
endmodule
`default_nettype wire

// file: sim/per_reply_tb.sv
// Self-checking testbench of the packet error reply block
`timescale 1ns/100ps
`default_nettype none
module per_reply_tb;
   localparam int TMO = 50;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cmdValid = 1'b0;
   logic resValid = 1'b0;
   logic rptValid = 1'b0;
   logic plValid = 1'b0;
   logic hold = 1'b0;
   logic slow = 1'b0;
   logic [7:0] plData = 8'h00;
   per_pkg::per_cmd_s cmd = '0;
   per_pkg::per_res_s res = '0;
   per_pkg::per_rpt_s rpt = '0;
   per_pkg::per_tx_s txData;
   logic cmdReady, rptReady, plReady, plForReport, txValid, txReady;
   int n_errors = 0;
   int cmp_count = 0;

   always #4 clk = ~clk;

   per_reply #(.TIMEOUT_CYC(TMO)) i_dut (.clk(clk), .rst(rst), .cmdValid(cmdValid), .cmd(cmd),
      .cmdReady(cmdReady), .resValid(resValid), .res(res), .rptValid(rptValid), .rpt(rpt),
      .rptReady(rptReady), .plValid(plValid), .plData(plData), .plReady(plReady),
      .plForReport(plForReport), .txValid(txValid), .txReady(txReady), .txData(txData));
   per_host_model i_host (.clk(clk), .rst(rst), .txValid(txValid), .txData(txData), .hold(hold),
      .slow(slow), .txReady(txReady));

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic wrap_up;
      if (n_errors == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic give_up;
      n_errors++;
      $display("[FAIL] handshake expected done seen timeout");
      wrap_up();
   endtask

   function automatic logic [15:0] crc16(input logic [7:0] b[$]);
      logic [15:0] c;
      c = per_pkg::CRC_INIT;
      foreach (b[i]) begin
         c = c ^ {8'h00, b[i]};
         for (int k = 0; k < 8; k++) begin
            c = c[0] ? ((c >> 1) ^ per_pkg::CRC_POLY) : (c >> 1);
         end
      end
      return c ^ per_pkg::CRC_XOROUT;
   endfunction

   // Ready is judged at the falling edge, the transfer lands on the next rise
   task automatic hs(input int w, input logic pf);
      logic r;
      for (int i = 0; i < 2000; i++) begin
         @(negedge clk);
         r = (w == 0) ? cmdReady : (w == 1) ? rptReady : plReady;
         if (w == 2 && r === 1'b1) begin
            chk("plForReport", 16'(plForReport), 16'(pf));
         end
         @(posedge clk);
         if (r === 1'b1) begin
            return;
         end
      end
      give_up();
   endtask

   // One command at a time: callers wait for the reply first
   task automatic send_cmd(input logic [7:0] t, input logic usb);
      cmd <= '{cmdType: t, usb: usb};
      cmdValid <= 1'b1;
      hs(0, 1'b0);
      cmdValid <= 1'b0;
   endtask

   task automatic send_res(input logic f, input logic s, input logic [7:0] sn, input logic [7:0] e,
                           input logic [7:0] n);
      res <= '{fail: f, isSub: s, subNum: sn, errId: e, len: n};
      resValid <= 1'b1;
      @(posedge clk);
      resValid <= 1'b0;
   endtask

   task automatic send_pl(input int n, input logic [7:0] base, input logic pf);
      for (int j = 0; j < n; j++) begin
         plData <= base + 8'(j);
         plValid <= 1'b1;
         hs(2, pf);
      end
      plValid <= 1'b0;
   endtask

   // Bytes are taken in arrival order; a whole packet is compared with its check code
   task automatic chk_pkt(input logic [7:0] t, input logic [1:0] dest, input logic [7:0] d[$]);
      logic [7:0] e[$];
      logic [15:0] c;
      per_pkg::per_tx_s got;
      e = {t, 8'(d.size())};
      e = {e, d};
      c = crc16(e);
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
      for (int i = 0; i < 3000 && i_host.rxQ.size() < e.size(); i++) begin
         @(posedge clk);
      end
      if (i_host.rxQ.size() < e.size()) begin
         give_up();
      end
      foreach (e[i]) begin
         got = i_host.rxQ.pop_front();
         chk("txByte", {8'h00, got.data}, {8'h00, e[i]});
         chk("txDest", 16'(got.dest), 16'(dest));
      end
   endtask

   task automatic chk_none;
      repeat (20) @(posedge clk);
      chk("extraBytes", 16'(i_host.rxQ.size()), 16'h0000);
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic s_std_errors;
      logic u;
      slow <= 1'b1;
      for (int e = 1; e <= 24; e++) begin
         u = e[0];
         send_cmd({2'b00, 6'(e + 8)}, u);
         send_res(1'b1, 1'b0, 8'h00, 8'(e), 8'h00);
         chk_pkt({2'b11, 6'(e + 8)}, u ? per_pkg::DEST_USB : per_pkg::DEST_SERIAL,
                 {u ? per_pkg::IF_USB : per_pkg::IF_SERIAL, 8'(e)});
      end
      slow <= 1'b0;
      chk_none();
   endtask

   task automatic s_sub_and_range;
      send_cmd(8'h27, 1'b1);
      @(negedge clk);
      chk("cmdReady", 16'(cmdReady), 16'h0000);
      @(posedge clk);
      send_res(1'b1, 1'b1, 8'h03, per_pkg::ERR_CARD_LAST, 8'h00);
      chk_pkt(8'hE7, per_pkg::DEST_USB, {8'h03, per_pkg::IF_USB, per_pkg::ERR_CARD_LAST});
      send_cmd(8'h05, 1'b0);
      send_res(1'b1, 1'b0, 8'h00, 8'h30, 8'h00);
      chk_pkt(8'hC5, per_pkg::DEST_SERIAL, {per_pkg::IF_SERIAL, per_pkg::ERR_UNKNOWN});
   endtask

   // No result in time: the deadline forces an unknown-error reply
   task automatic s_timeout;
      send_cmd(8'h02, 1'b1);
      repeat (TMO - 10) @(posedge clk);
      chk("earlyReply", 16'(i_host.rxQ.size()), 16'h0000);
      repeat (20) @(posedge clk);
      chk("lateReply", 16'(i_host.rxQ.size() != 0), 16'h0001);
      chk_pkt(8'hC2, per_pkg::DEST_USB, {per_pkg::IF_USB, per_pkg::ERR_UNKNOWN});
      send_res(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
      chk_none();
   endtask

   task automatic s_normal;
      logic [7:0] none[$];
      send_cmd(8'h01, 1'b0);
      send_res(1'b0, 1'b0, 8'h00, 8'h00, 8'h03);
      send_pl(3, 8'hA0, 1'b0);
      chk_pkt(8'h41, per_pkg::DEST_SERIAL, {8'hA0, 8'hA1, 8'hA2});
      send_cmd(8'h04, 1'b1);
      send_res(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
      chk_pkt(8'h44, per_pkg::DEST_USB, none);
      chk_none();
   endtask

   task automatic s_report_between;
      logic [7:0] none[$];
      send_cmd(8'h0E, 1'b0);
      rpt <= '{code: 6'h01, len: 8'h01};
      rptValid <= 1'b1;
      hs(1, 1'b1);
      rptValid <= 1'b0;
      send_pl(1, 8'h5A, 1'b1);
      chk_pkt(8'h81, per_pkg::DEST_ALL, {8'h5A});
      send_res(1'b1, 1'b0, 8'h00, per_pkg::ERR_BAD_LEN, 8'h00);
      // Report raised while the reply is ready: the reply must go out first
      rpt <= '{code: 6'h02, len: 8'h00};
      rptValid <= 1'b1;
      hs(1, 1'b1);
      rptValid <= 1'b0;
      chk_pkt(8'hCE, per_pkg::DEST_SERIAL, {per_pkg::IF_SERIAL, per_pkg::ERR_BAD_LEN});
      chk_pkt(8'h82, per_pkg::DEST_ALL, none);
      chk_none();
   endtask

   // Host blocked long enough for the buffer to fill and refuse payload
   task automatic s_backpressure;
      logic [7:0] q[$];
      for (int j = 0; j < 10; j++) begin
         q.push_back(8'h10 + 8'(j));
      end
      hold <= 1'b1;
      send_cmd(8'h1F, 1'b1);
      send_res(1'b0, 1'b0, 8'h00, 8'h00, 8'h0A);
      fork
         send_pl(10, 8'h10, 1'b0);
         begin
            repeat (40) @(posedge clk);
            chk("txValid", 16'(txValid), 16'h0001);
            chk("heldBytes", 16'(i_host.rxQ.size()), 16'h0000);
            hold <= 1'b0;
         end
      join
      chk_pkt(8'h5F, per_pkg::DEST_USB, q);
      chk_none();
   endtask

   initial begin
      @(negedge clk);
      chk("cmdReadyRst", 16'(cmdReady), 16'h0001);
      chk("txValidRst", 16'(txValid), 16'h0000);
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      s_std_errors();
      s_sub_and_range();
      s_timeout();
      s_normal();
      s_report_between();
      s_backpressure();
      wrap_up();
   end
endmodule
`default_nettype wire
